/* include/waveform_extension_regs.svh */
// Register offsets, field positions and reset values of the waveform extension
`ifndef WAVEFORM_EXTENSION_REGS_SVH
`define WAVEFORM_EXTENSION_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define AXI_AW 8
`define DT_W 8
`define PIN_W 8
`define EVT_W 8
`define CTRL_W 7
`define ST_W 2

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_FAULT_SEL 8'h04
`define OFS_STATUS 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_DT_BUF 8'h10
`define OFS_PAT_BUF 8'h14
`define OFS_PORT_OVR 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_PAT_BIT 4
`define CTRL_DIST_BIT 5
`define CTRL_HALT_BIT 6
`define ST_FAULT_BIT 0
`define ST_UPD_BIT 1

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define RST_CTRL 7'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* include/wave_ext_pkg.sv */
// Types shared by the waveform extension modules
`include "waveform_extension_regs.svh"
package wave_ext_pkg;

  typedef struct packed {
    logic [`AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic awPend;
    logic [`AXI_AW-1:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic [3:0] wStrb;
    axi_rsp_t rsp;
  } slv_state_t;

  typedef struct packed {
    logic prevWave;
    logic [`DT_W-1:0] count;
    logic lowOn;
    logic highOn;
  } dead_state_t;

  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    logic [`EVT_W-1:0] faultSel;
    logic [`ST_W-1:0] status;
    logic [`ST_W-1:0] intMask;
    logic [`DT_W-1:0] dtLowBuf;
    logic [`DT_W-1:0] dtHighBuf;
    logic [`DT_W-1:0] dtLow;
    logic [`DT_W-1:0] dtHigh;
    logic [`PIN_W-1:0] patBuf;
    logic [`PIN_W-1:0] patOvrBuf;
    logic [`PIN_W-1:0] pat;
    logic [`PIN_W-1:0] patOvr;
    logic [`PIN_W-1:0] ovr;
    logic [`PIN_W-1:0] portOut;
    logic [`PIN_W-1:0] portOvr;
    logic timerHalt;
    logic irq;
  } top_state_t;

endpackage

/* hdl/axi_lite_slave.sv */
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "waveform_extension_regs.svh"
module axi_lite_slave import wave_ext_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire axi_req_t axiReq,
  output axi_rsp_t axiRsp,
  output logic wrEn,
  output logic [`AXI_AW-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic rdEn,
  output logic [`AXI_AW-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);

  slv_state_t s;
  slv_state_t n;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  // Address and data are held separately so either may arrive first
  always_comb begin
    n = s;
    wrEn = 1'b0;
    rdEn = axiReq.arvalid && s.rsp.arready;
    if (axiReq.awvalid && s.rsp.awready) begin
      n.awPend = 1'b1;
      n.awAddr = axiReq.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      n.wPend = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (s.rsp.bvalid && axiReq.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.awPend && s.wPend && !s.rsp.bvalid) begin
      wrEn = 1'b1;
      n.awPend = 1'b0;
      n.wPend = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready = 1'b1;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = wrOk ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s.rsp.rvalid && axiReq.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end
    if (rdEn) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = rdOk ? rdData : 32'h0;
      n.rsp.rresp = rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign axiRsp = s.rsp;
  assign wrAddr = s.awAddr;
  assign wrData = s.wData;
  assign wrStrb = s.wStrb;
  assign rdAddr = axiReq.araddr;

endmodule
`default_nettype wire

/* hdl/dead_time_inserter.sv */
// One dead-time inserter: complementary low and high side from one waveform
`timescale 1ns/1ps
`default_nettype none
`include "waveform_extension_regs.svh"
module dead_time_inserter import wave_ext_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wave,
  input wire logic [`DT_W-1:0] lowDead,
  input wire logic [`DT_W-1:0] highDead,
  output logic lowSide,
  output logic highSide,
  output logic inDead
);

  dead_state_t s;
  dead_state_t n;

  // ----------------------------------------------------------------
  // Dead-time sequencing
  // ----------------------------------------------------------------
  // An edge with a nonzero count switches both sides off first; the side that turns on
  // waits its own count, so the switches never conduct together
  always_comb begin
    n = s;
    n.prevWave = wave;
    if (wave != s.prevWave) begin
      n.count = wave ? lowDead : highDead;
      n.lowOn = wave && (n.count == '0);
      n.highOn = !wave && (n.count == '0);
    end else if (s.count > `DT_W'(1)) begin
      n.count = s.count - `DT_W'(1);
    end else begin
      n.count = '0;
      n.lowOn = wave;
      n.highOn = !wave;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lowSide = s.lowOn;
  assign highSide = s.highOn;
  assign inDead = (s.count != '0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_no_overlap: assert property (!(s.lowOn && s.highOn))
    else $error("both sides on together");
  a_low_polarity: assert property (s.lowOn |-> s.prevWave)
    else $error("low side on while waveform low");
  a_low_load: assert property ((wave && !s.prevWave && lowDead != '0) |=>
    (s.count == $past(lowDead) && !s.lowOn && !s.highOn))
    else $error("low-side dead time not loaded");
  a_high_load: assert property ((!wave && s.prevWave && highDead != '0) |=>
    (s.count == $past(highDead) && !s.lowOn && !s.highOn))
    else $error("high-side dead time not loaded");
  a_count_end: assert property ((s.count == `DT_W'(1) && wave == s.prevWave) |=>
    (s.lowOn == $past(wave) && s.highOn == !$past(wave)))
    else $error("side not switched at end of dead time");

endmodule
`default_nettype wire

/* hdl/waveform_extension.sv */
// Waveform extension: dead-time pairs, pattern generator, fault unit, bus slave
`timescale 1ns/1ps
`default_nettype none
`include "waveform_extension_regs.svh"

// Overview of operation
// - Each enabled channel splits its waveform into a pair
// - Low side follows waveform, high side inverted
// - Four inserters, eight-bit dead time counts
// - High and low dead times set separately
// - Dead times load from buffer at update
// - Optional timer halt during dead time
// - Override mask picks pins taking pair outputs
// - Pattern drives pins, loaded at update
// - Distribution puts channel A on all pins
// - Pattern mode bypasses the dead-time inserters
// - Selected event forces fault, outputs off
module waveform_extension import wave_ext_pkg::*; #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire axi_req_t axiReq,
  output axi_rsp_t axiRsp,
  input wire logic [CHANNELS-1:0] waveIn,
  input wire logic timerUpdate,
  input wire logic [`EVT_W-1:0] faultEvent,
  output logic [`PIN_W-1:0] portOut,
  output logic [`PIN_W-1:0] portOverride,
  output logic timerHalt,
  output logic irq
);

  top_state_t s;
  top_state_t n;

  logic wrEn;
  logic rdEn;
  logic wrOk;
  logic rdOk;
  logic [`AXI_AW-1:0] wrAddr;
  logic [`AXI_AW-1:0] rdAddr;
  logic [31:0] wrData;
  logic [31:0] rdData;
  logic [3:0] wrStrb;
  logic [31:0] wMask;
  logic [31:0] wVal;
  logic [31:0] wClr;
  logic [`ST_W-1:0] stClr;
  logic faultTrig;
  logic [CHANNELS-1:0] pairEn;
  logic [CHANNELS-1:0] lowSide;
  logic [CHANNELS-1:0] highSide;
  logic [CHANNELS-1:0] inDead;
  logic [`PIN_W-1:0] pairPins;
  logic [`PIN_W-1:0] pairOvr;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Unmapped offsets answer with an error and read as zero
  function automatic logic isMapped(input logic [`AXI_AW-1:0] a);
    case (a)
      `OFS_CTRL, `OFS_FAULT_SEL, `OFS_STATUS, `OFS_INT_MASK,
      `OFS_DT_BUF, `OFS_PAT_BUF, `OFS_PORT_OVR: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] readReg(input top_state_t t,
                                          input logic [`AXI_AW-1:0] a);
    case (a)
      `OFS_CTRL: readReg = 32'(t.ctrl);
      `OFS_FAULT_SEL: readReg = 32'(t.faultSel);
      `OFS_STATUS: readReg = 32'(t.status);
      `OFS_INT_MASK: readReg = 32'(t.intMask);
      `OFS_DT_BUF: readReg = 32'({t.dtHighBuf, t.dtLowBuf});
      `OFS_PAT_BUF: readReg = 32'({t.patOvrBuf, t.patBuf});
      `OFS_PORT_OVR: readReg = 32'(t.ovr);
      default: readReg = 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] strbMask(input logic [3:0] b);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{b[i]}};
    end
    strbMask = m;
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  axi_lite_slave u_axi_lite_slave (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  assign wrOk = isMapped(wrAddr);
  assign rdOk = isMapped(rdAddr);
  assign rdData = readReg(s, rdAddr);
  assign wMask = strbMask(wrStrb);
  assign wVal = (readReg(s, wrAddr) & ~wMask) | (wrData & wMask);
  assign wClr = wrData & wMask;
  assign stClr = (wrEn && wrAddr == `OFS_STATUS) ? wClr[`ST_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Dead-time inserters
  // ----------------------------------------------------------------
  assign pairEn = s.ctrl[CHANNELS-1:0];

  // One shared dead-time pair; each channel has its own counter.
  // Pin 2k carries the low side of channel k, pin 2k+1 its high side.
  generate
    for (genvar k = 0; k < CHANNELS; k++) begin : gen_pair
      dead_time_inserter u_dead_time_inserter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wave(waveIn[k]),
        .lowDead(s.dtLow),
        .highDead(s.dtHigh),
        .lowSide(lowSide[k]),
        .highSide(highSide[k]),
        .inDead(inDead[k])
      );
      assign pairPins[2*k] = lowSide[k];
      assign pairPins[2*k+1] = highSide[k];
      assign pairOvr[2*k +: 2] = s.ovr[2*k +: 2] & {2{pairEn[k]}};
    end
  endgenerate

  assign faultTrig = |(faultEvent & s.faultSel);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // Status is not written here: software clears it bit by bit below
    if (wrEn) begin
      case (wrAddr)
        `OFS_CTRL: n.ctrl = wVal[`CTRL_W-1:0];
        `OFS_FAULT_SEL: n.faultSel = wVal[`EVT_W-1:0];
        `OFS_INT_MASK: n.intMask = wVal[`ST_W-1:0];
        `OFS_DT_BUF: begin
          n.dtLowBuf = wVal[`DT_W-1:0];
          n.dtHighBuf = wVal[2*`DT_W-1:`DT_W];
        end
        `OFS_PAT_BUF: begin
          n.patBuf = wVal[`PIN_W-1:0];
          n.patOvrBuf = wVal[2*`PIN_W-1:`PIN_W];
        end
        `OFS_PORT_OVR: n.ovr = wVal[`PIN_W-1:0];
        default: begin
        end
      endcase
    end

    // A new event in the clearing cycle keeps its flag set
    n.status = (s.status & ~stClr);
    n.status[`ST_FAULT_BIT] = n.status[`ST_FAULT_BIT] | faultTrig;
    n.status[`ST_UPD_BIT] = n.status[`ST_UPD_BIT] | timerUpdate;

    // Buffers move to active only at the timer update point
    if (timerUpdate) begin
      n.dtLow = s.dtLowBuf;
      n.dtHigh = s.dtHighBuf;
      n.pat = s.patBuf;
      n.patOvr = s.patOvrBuf;
    end

    // Fault beats every mode; outputs forced low, not released to port
    if (n.status[`ST_FAULT_BIT]) begin
      n.portOut = '0;
      n.portOvr = '1;
    end else if (s.ctrl[`CTRL_DIST_BIT]) begin
      n.portOut = {`PIN_W{waveIn[0]}};
      n.portOvr = '1;
    end else if (s.ctrl[`CTRL_PAT_BIT]) begin
      n.portOut = s.pat;
      n.portOvr = s.patOvr;
    end else if (|pairEn) begin
      n.portOut = pairPins;
      n.portOvr = pairOvr;
    end else begin
      n.portOut = '0;
      n.portOvr = '0;
    end

    // Halt is suppressed while pattern mode bypasses the inserters
    n.timerHalt = s.ctrl[`CTRL_HALT_BIT] && !s.ctrl[`CTRL_PAT_BIT] &&
                  (|(inDead & pairEn));
    n.irq = |(n.status & n.intMask);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign portOut = s.portOut;
  assign portOverride = s.portOvr;
  assign timerHalt = s.timerHalt;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Pins stay with the port while every feature is off
  a_split_off: assert property ((s.ctrl[5:0] == 6'h00 && !n.status[0]) |=>
    (portOverride == '0))
    else $error("pins overridden with no feature enabled");

  // Active dead times move only at the update point
  a_dt_update: assert property (timerUpdate |=>
    (s.dtLow == $past(s.dtLowBuf) && s.dtHigh == $past(s.dtHighBuf)))
    else $error("dead time not loaded at update");

  a_dt_hold: assert property (!timerUpdate |=>
    ($stable(s.dtLow) && $stable(s.dtHigh)))
    else $error("dead time changed between updates");

  a_halt_on: assert property ((s.ctrl[6] && !s.ctrl[4] && |(inDead & pairEn)) |=>
    timerHalt)
    else $error("timer not halted during dead time");

  a_halt_off: assert property ((!s.ctrl[6]) |=> !timerHalt)
    else $error("timer halted without halt option");

  // The timer must resume as soon as no enabled channel is in dead time
  a_halt_end: assert property ((~|(inDead & pairEn)) |=> !timerHalt)
    else $error("timer still halted after dead time");

  a_pin_select: assert property ((pairEn != '0 && s.ctrl[5:4] == 2'h0 &&
    !n.status[0]) |=> (portOverride == $past(pairOvr) &&
    portOut == $past(pairPins)))
    else $error("override mask not applied to pair outputs");

  a_pat_load: assert property (timerUpdate |=>
    (s.pat == $past(s.patBuf) && s.patOvr == $past(s.patOvrBuf)))
    else $error("pattern not loaded at update");

  a_pat_hold: assert property (!timerUpdate |=>
    ($stable(s.pat) && $stable(s.patOvr)))
    else $error("pattern changed between updates");

  a_distribute: assert property ((s.ctrl[5] && !n.status[0]) |=>
    (portOut == {`PIN_W{$past(waveIn[0])}} && portOverride == '1))
    else $error("channel A not distributed to all pins");

  a_pat_bypass: assert property ((s.ctrl[4] && !s.ctrl[5] && !n.status[0]) |=>
    (portOut == $past(s.pat) && portOverride == $past(s.patOvr) &&
    !timerHalt))
    else $error("pattern mode did not bypass inserters");

  a_halt_bypass: assert property (s.ctrl[4] |=> !timerHalt)
    else $error("timer halted while inserters bypassed");

  a_fault_off: assert property (faultTrig |=>
    (portOut == '0 && portOverride == '1 && s.status[0]))
    else $error("fault event did not disable outputs");

  // A new event must win over a clear written in the same cycle
  a_fault_wins: assert property ((faultTrig && stClr[0]) |=> s.status[0])
    else $error("clear beat a new fault event");

  // One cycle ahead only: software may clear in the very next cycle
  a_fault_hold: assert property ((s.status[0] && !stClr[0]) |=>
    (s.status[0] && portOut == '0 && portOverride == '1))
    else $error("fault released without software clear");

  a_fault_clear: assert property ((s.status[0] && stClr[0] && !faultTrig) |=>
    !s.status[0])
    else $error("fault flag not cleared by software");

  a_update_flag: assert property (timerUpdate |=> s.status[1])
    else $error("update flag not set at update");

  a_irq_level: assert property (irq == |(s.status & s.intMask))
    else $error("interrupt does not follow unmasked status");

  // Main scenarios
  c_fault: cover property (faultTrig ##1 s.status[0] ##[1:100] !s.status[0]);
  c_distribute: cover property (s.ctrl[5] && !s.status[0] ##1 portOut == '1);
  c_halt: cover property (!timerHalt ##1 timerHalt[*2]);
  c_pattern: cover property (s.ctrl[4] && timerUpdate ##2 portOut != '0);
  c_pairs: cover property (pairEn == '1 && s.ovr != '0 ##1 portOverride != '0);

endmodule
`default_nettype wire

/* verification/switch_driver_model.sv */
// Behavioural model of the external high- and low-side switch drivers
`timescale 1ns/1ps
`default_nettype none
module switch_driver_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pairMode,
  input wire logic [7:0] portOut,
  input wire logic [7:0] portOverride,
  output var logic [7:0] gate,
  output var int overlapCount
);
  // Pins left to the port idle low, so a released pin never turns a switch on
  always_comb begin
    gate = portOut & portOverride;
  end
  // Both switches of one leg on together would short the supply
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      overlapCount <= 0;
    end else if (pairMode) begin
      for (int k = 0; k < 4; k++) begin
        if (gate[2*k] && gate[2*k+1]) overlapCount <= overlapCount + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/waveform_extension_test.sv */
// Self-checking bench for the waveform extension
`timescale 1ns/1ps
`default_nettype none
`include "waveform_extension_regs.svh"
module waveform_extension_test import wave_ext_pkg::*; ();
  localparam logic [31:0] WMASK [7] = '{32'h7F, 32'hFF, 32'h3, 32'h3, 32'hFFFF, 32'hFFFF, 32'hFF};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  logic [3:0] waveIn = 4'h0;
  logic timerUpdate = 1'b0;
  logic [7:0] faultEvent = 8'h00;
  logic [7:0] portOut;
  logic [7:0] portOverride;
  logic [7:0] gate;
  logic timerHalt;
  logic irq;
  logic pairMode = 1'b0;
  logic halted;
  logic [31:0] rdv;
  logic [1:0] resp;
  logic [31:0] model [7];
  int overlapCount;
  int bad_count = 0;
  int checks_done = 0;
  int dl;
  int dh;
  int j;

  always #5 sys_clk = ~sys_clk;

  waveform_extension u_waveform_extension (
    .sys_clk(sys_clk), .rst_b(rst_b), .axiReq(req), .axiRsp(rsp), .waveIn(waveIn),
    .timerUpdate(timerUpdate), .faultEvent(faultEvent), .portOut(portOut),
    .portOverride(portOverride), .timerHalt(timerHalt), .irq(irq)
  );
  switch_driver_model u_switch_driver_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .pairMode(pairMode), .portOut(portOut),
    .portOverride(portOverride), .gate(gate), .overlapCount(overlapCount)
  );

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && rsp.awready === 1'b1) begin
        awDone = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!wDone && rsp.wready === 1'b1) begin
        wDone = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge sys_clk);
    resp = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge sys_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
    rdv = rsp.rdata;
    resp = rsp.rresp;
  endtask

  task automatic setr(input int i, input logic [31:0] v);
    wr(8'(i * 4), v);
    model[i] = v & WMASK[i];
  endtask

  task automatic ck(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic upd();
    @(posedge sys_clk);
    timerUpdate <= 1'b1;
    @(posedge sys_clk);
    timerUpdate <= 1'b0;
    model[2] = model[2] | 32'h2;
  endtask

  // Edge on channel A, then count cycles until the new side comes on
  task automatic dead_run(input logic w, input int d);
    int k;
    @(posedge sys_clk);
    waveIn[0] <= w;
    k = 0;
    halted = 1'b0;
    do begin
      ck(1);
      k++;
      if (timerHalt === 1'b1) halted = 1'b1;
    end while (portOut[w ? 0 : 1] !== 1'b1 && k < 300);
    chk("dead time", 32'(k), 32'(d + 2));
    chk("other side", 32'(portOut[w ? 1 : 0]), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(70));
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    for (int i = 0; i < 7; i++) model[i] = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk("reset value", rdv, 32'h0);
    end
    for (int i = 0; i < 7; i++) if (i != 2) setr(i, $urandom);
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk("readback", rdv, model[i]);
      chk("read resp", 32'(resp), 32'(`RESP_OKAY));
    end
    wr(8'h1C, 32'hFFFFFFFF);
    chk("unmapped write", 32'(resp), 32'(`RESP_SLVERR));
    rd(8'h40);
    chk("unmapped read", rdv, 32'h0);
    chk("unmapped rresp", 32'(resp), 32'(`RESP_SLVERR));
    for (int i = 0; i < 7; i++) if (i != 2) setr(i, 32'h0);
    // Channel A pair with timer halt
    dl = 1 + $urandom % 20;
    dh = 1 + $urandom % 20;
    setr(6, 32'hFF);
    setr(0, 32'h41);
    setr(4, 32'(dh * 256 + dl));
    upd();
    pairMode <= 1'b1;
    ck(4);
    chk("pair override", 32'(portOverride), 32'h3);
    chk("idle pair", 32'(portOut[1:0]), 32'h2);
    dead_run(1'b1, dl);
    chk("halt seen", 32'(halted), 32'h1);
    ck(3);
    chk("halt released", 32'(timerHalt), 32'h0);
    dead_run(1'b0, dh);
    setr(4, 32'((dl + 5) * 256 + dh + 7));
    dead_run(1'b1, dl);
    upd();
    dead_run(1'b0, dl + 5);
    // All four pairs behind a partial override mask
    setr(6, 32'h5B);
    setr(0, 32'h0F);
    @(posedge sys_clk);
    waveIn <= 4'($urandom);
    ck(60);
    for (int k = 0; k < 4; k++) begin
      chk("four pairs", 32'(portOut[2*k+:2]), 32'({~waveIn[k], waveIn[k]}));
    end
    chk("mask", 32'(portOverride), 32'h5B);
    // Pattern: waits for the update, no halt while it bypasses the pairs
    setr(0, 32'h51);
    pairMode <= 1'b0;
    setr(5, $urandom);
    @(posedge sys_clk);
    waveIn[0] <= ~waveIn[0];
    ck(3);
    chk("pattern held", 32'({portOverride, portOut}), 32'h0);
    chk("no halt", 32'(timerHalt), 32'h0);
    upd();
    ck(3);
    chk("pattern", 32'({portOverride, portOut}), model[5]);
    // Distribution of channel A
    setr(0, 32'h30);
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      waveIn[0] <= v[0];
      ck(2);
      chk("dist", 32'({portOverride, portOut}), {16'h0, 8'hFF, {8{v[0]}}});
    end
    // Fault: raise, mask, clear
    j = $urandom % 8;
    setr(1, 32'(1 << j));
    setr(3, 32'h0);
    @(posedge sys_clk);
    faultEvent[j] <= 1'b1;
    @(posedge sys_clk);
    faultEvent <= 8'h00;
    #1;
    model[2] = model[2] | 32'h1;
    chk("fault out", 32'({portOverride, portOut}), 32'hFF00);
    chk("masked irq", 32'(irq), 32'h0);
    rd(`OFS_STATUS);
    chk("status", rdv, model[2]);
    setr(3, 32'h1);
    ck(2);
    chk("irq", 32'(irq), 32'h1);
    chk("held off", 32'({portOverride, portOut}), 32'hFF00);
    wr(`OFS_STATUS, 32'h1);
    model[2] = model[2] & 32'h2;
    ck(2);
    chk("resume", 32'({portOverride, portOut}), 32'hFFFF);
    chk("irq clear", 32'(irq), 32'h0);
    @(posedge sys_clk);
    faultEvent <= 8'(~(1 << j));
    ck(3);
    chk("unselected", 32'({portOverride, portOut}), 32'hFFFF);
    @(posedge sys_clk);
    faultEvent <= 8'h00;
    rd(`OFS_STATUS);
    chk("status after", rdv, model[2]);
    chk("overlap", 32'(overlapCount), 32'h0);
    report_and_stop();
  end

  // A hang counts as a mismatch
  initial begin
    #300us;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
